/* File: design/srm_pkg.sv */
// constants and types shared by the shadow and roll address mapper
package srm_pkg;

	// local i/o offsets of the mapping registers
	localparam logic [7:0] SRM_CFG_OFS  = 8'h22;
	localparam logic [7:0] SRM_GRAN_OFS = 8'h2c;
	localparam logic [7:0] SRM_SEG_OFS  = 8'h2e;

	// configuration register field positions
	localparam int SRM_CFG_BIOS_BIT   = 0;
	localparam int SRM_CFG_BASE_BIT   = 3;
	localparam int SRM_CFG_DSIZE_BIT  = 4;
	localparam int SRM_CFG_BANK_LSB   = 6;
	localparam int SRM_CFG_ADP_BIT    = 9;
	localparam int SRM_CFG_VIDEO_BIT  = 10;
	localparam int SRM_CFG_LOCK_BIT   = 15;

	// granularity enable and segment control field positions
	localparam int SRM_GRAN_FINE_BIT  = 0;
	localparam int SRM_SEG_SHADOW_LSB = 0;
	localparam int SRM_SEG_WP_LSB     = 8;

	// reset values
	localparam logic [15:0] SRM_CFG_RST  = 16'h0000;
	localparam logic [15:0] SRM_GRAN_RST = 16'h0000;
	localparam logic [15:0] SRM_SEG_RST  = 16'h0000;

	// 128 kbyte block numbers, address bits 23:17
	localparam logic [6:0] SRM_BLK_ALIAS = 7'h7f;
	localparam logic [6:0] SRM_BLK_EXTRA = 7'h04;
	localparam logic [6:0] SRM_BLK_VIDEO = 7'h05;
	localparam logic [6:0] SRM_BLK_ADP   = 7'h06;
	localparam logic [6:0] SRM_BLK_BIOS  = 7'h07;

	// rollable physical areas; the code plus 4 is the physical block
	typedef enum logic [1:0] {
		SRM_AREA_EXTRA,
		SRM_AREA_VIDEO,
		SRM_AREA_ADP,
		SRM_AREA_BIOS
	} srm_area_t;

endpackage

/* File: design/srm_roll_order.sv */
// roll block to physical area ordering for the address mapper
`timescale 1ns/1ps
module srm_roll_order
	import srm_pkg::*;
(
	input  wire logic [3:0] elig,  // eligible areas, indexed by area code
	input  wire logic [1:0] blk,   // roll block, 0 is block a
	output srm_area_t       area,  // physical area for this block
	output logic      [2:0] count  // number of eligible areas
);

	// population count of the eligible set
	function automatic logic [2:0] srm_ones(input logic [3:0] v);
		logic [2:0] n;
		n = 3'h0;
		for (int i = 0; i < 4; i++) begin
			n = n + {2'h0, v[i]};
		end
		return n;
	endfunction

	// priority walk bios, adapter, video, extra with two special orders
	always_comb begin
		logic [2:0] k;
		k = 3'h0;
		area = SRM_AREA_BIOS;
		count = srm_ones(elig);
		if (elig == 4'hf) begin
			area = srm_area_t'(blk);
		end else if (elig == 4'he) begin
			unique case (blk)
				2'h0: area = SRM_AREA_BIOS;
				2'h1: area = SRM_AREA_VIDEO;
				default: area = SRM_AREA_ADP;
			endcase
		end else begin
			for (int i = 3; i >= 0; i--) begin
				if (elig[i]) begin
					if (k == {1'b0, blk}) begin
						area = srm_area_t'(i[1:0]);
					end
					k = k + 3'h1;
				end
			end
		end
	end

endmodule

/* File: design/srm_mapper.sv */
// shadow and roll address mapper with its local i/o registers
`timescale 1ns/1ps
module srm_mapper
	import srm_pkg::*;
(
	input  wire logic        clk,         // processor clock, 25 mhz
	input  wire logic        srst,        // synchronous reset, high
	input  wire logic        ce,          // clock enable, freezes state
	input  wire logic [7:0]  io_addr,     // local i/o address
	input  wire logic        io_wr,       // i/o write strobe
	input  wire logic        io_rd,       // i/o read strobe
	input  wire logic [15:0] io_wdata,    // i/o write data
	output logic      [15:0] io_rdata,    // i/o read data, registered
	input  wire logic        cpu_valid,   // memory cycle present
	input  wire logic        cpu_write,   // memory cycle is a write
	input  wire logic [23:1] cpu_addr,    // processor word address
	input  wire logic [4:0]  roll_base,   // roll region, 512k units
	input  wire logic [2:0]  roll_blocks, // 128k blocks in region
	output logic             dram_sel,    // cycle served by dram
	output logic             rom_sel,     // cycle served by rom
	output logic             video_sel,   // cycle to system video ram
	output logic      [23:1] phys_addr,   // dram physical address
	output logic             wp_refused,  // write dropped, protected
	output logic             fine_mode    // 32k granularity active
);

	////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		logic [15:0] cfg;
		logic [15:0] gran;
		logic [15:0] seg;
		logic [15:0] rdata;
		logic        dram;
		logic        rom;
		logic        video;
		logic [23:1] paddr;
		logic        wp;
	} srm_state_t;

	srm_state_t st;
	srm_state_t next_st;

	////////////////////////////////////////////////////////////////////
	// decode helpers

	logic       locked;
	logic       fine;
	logic       sh_bios;
	logic       sh_adp;
	logic       sh_video;
	logic       mem_1mb;
	logic [6:0] blk;
	logic [3:0] elig;
	logic       roll_hit;
	logic       roll_ok;
	srm_area_t  roll_area;
	logic [2:0] elig_n;
	logic [2:0] seg_idx;
	logic       seg_sh;
	logic       seg_wp;
	logic       area_sh;

	// per-segment shadow and protect bits, index 0 is c0000
	function automatic logic srm_bit(input logic [7:0] v,
		input logic [2:0] i);
		return v[i];
	endfunction

	assign locked   = st.cfg[SRM_CFG_LOCK_BIT];
	assign fine     = st.gran[SRM_GRAN_FINE_BIT];
	assign sh_bios  = st.cfg[SRM_CFG_BIOS_BIT];
	assign sh_adp   = st.cfg[SRM_CFG_ADP_BIT];
	assign sh_video = st.cfg[SRM_CFG_VIDEO_BIT];
	// 1mb chips, or two or more banks of 256k, give at least 1mbyte
	assign mem_1mb  = st.cfg[SRM_CFG_DSIZE_BIT]
		| (st.cfg[SRM_CFG_BANK_LSB +: 2] != 2'h0);
	assign blk      = cpu_addr[23:17];
	assign seg_idx  = cpu_addr[17:15];
	assign seg_sh   = srm_bit(st.seg[SRM_SEG_SHADOW_LSB +: 8], seg_idx);
	assign seg_wp   = srm_bit(st.seg[SRM_SEG_WP_LSB +: 8], seg_idx);

	// shadowed areas drop out of the rollable set
	assign elig = {~sh_bios, ~sh_adp, ~sh_video,
		~st.cfg[SRM_CFG_BASE_BIT]};

	// region matched on its own 512k window, no tie to dram top
	assign roll_hit = mem_1mb && (cpu_addr[23:19] == roll_base)
		&& ({1'b0, cpu_addr[18:17]} < roll_ok_blocks(roll_blocks, elig_n));
	assign roll_ok  = roll_hit;

	// blocks actually rolled, capped by areas available, at most 4
	function automatic logic [2:0] roll_ok_blocks(input logic [2:0] req,
		input logic [2:0] avail);
		return (req < avail) ? req : avail;
	endfunction

	srm_roll_order u_order (
		.elig  (elig),
		.blk   (cpu_addr[18:17]),
		.area  (roll_area),
		.count (elig_n)
	);

	// bios and adapter shadowing, with the 32k refinement when fine
	always_comb begin
		area_sh = 1'b0;
		if (blk == SRM_BLK_BIOS) begin
			area_sh = sh_bios && (!fine || seg_sh);
		end else if (blk == SRM_BLK_ADP) begin
			area_sh = sh_adp && (!fine || seg_sh);
		end
	end

	////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		next_st = st;
		if (ce) begin
			// register writes, refused while locked
			if (io_wr && !locked) begin
				unique case (io_addr)
					SRM_CFG_OFS:  next_st.cfg  = io_wdata;
					SRM_GRAN_OFS: next_st.gran = io_wdata &
						16'h0001;
					SRM_SEG_OFS:  next_st.seg  = io_wdata;
					default: ;
				endcase
			end
			// reads answer zero when locked or unmapped
			if (io_rd) begin
				next_st.rdata = 16'h0000;
				if (!locked) begin
					unique case (io_addr)
						SRM_CFG_OFS:  next_st.rdata = st.cfg;
						SRM_GRAN_OFS: next_st.rdata = st.gran;
						SRM_SEG_OFS:  next_st.rdata = st.seg;
						default: ;
					endcase
				end
			end
			// memory cycle routing, one cycle after the request
			next_st.dram  = 1'b0;
			next_st.rom   = 1'b0;
			next_st.video = 1'b0;
			next_st.wp    = 1'b0;
			next_st.paddr = cpu_addr;
			if (cpu_valid) begin
				if (blk == SRM_BLK_ALIAS) begin
					next_st.rom = 1'b1;
				end else if (blk == SRM_BLK_VIDEO) begin
					// same in both granularities
					next_st.dram  = sh_video;
					next_st.video = !sh_video;
				end else if (blk == SRM_BLK_BIOS
					|| blk == SRM_BLK_ADP) begin
					if (area_sh && fine && seg_wp && cpu_write) begin
						next_st.wp = 1'b1;
					end else begin
						next_st.dram = area_sh;
						next_st.rom  = !area_sh;
					end
				end else if (blk == SRM_BLK_EXTRA
					&& !st.cfg[SRM_CFG_BASE_BIT]) begin
					// 512k base: extra area is off board here
				end else if (roll_ok) begin
					next_st.dram  = 1'b1;
					next_st.paddr = {4'h0, 1'b1, roll_area,
						cpu_addr[16:1]};
				end else begin
					next_st.dram = 1'b1;
				end
			end
		end
		if (srst) begin
			next_st       = '0;
			next_st.cfg   = SRM_CFG_RST;
			next_st.gran  = SRM_GRAN_RST;
			next_st.seg   = SRM_SEG_RST;
		end
	end

	// single register for all state
	always_ff @(posedge clk) begin
		st <= next_st;
	end

	assign io_rdata   = st.rdata;
	assign dram_sel   = st.dram;
	assign rom_sel    = st.rom;
	assign video_sel  = st.video;
	assign phys_addr  = st.paddr;
	assign wp_refused = st.wp;
	assign fine_mode  = st.gran[SRM_GRAN_FINE_BIT];

	////////////////////////////////////////////////////////////////////
	// checks

	AST_ALIAS_ROM: assert property (@(posedge clk) disable iff (srst)
		ce && cpu_valid && cpu_addr[23:17] == SRM_BLK_ALIAS
		|=> rom_sel && !dram_sel && !video_sel)
		else $error("alias range not sent to rom");

	AST_BIOS_ROM: assert property (@(posedge clk) disable iff (srst)
		ce && cpu_valid && blk == SRM_BLK_BIOS && !sh_bios
		|=> rom_sel && !dram_sel)
		else $error("unshadowed bios not from rom");

	AST_ADP_DRAM: assert property (@(posedge clk) disable iff (srst)
		ce && cpu_valid && blk == SRM_BLK_ADP && sh_adp && !fine
		|=> dram_sel && !rom_sel)
		else $error("shadowed adapter area not from dram");

	AST_VIDEO_ROUTE: assert property (@(posedge clk) disable iff (srst)
		ce && cpu_valid && blk == SRM_BLK_VIDEO
		|=> (dram_sel == $past(sh_video)) && (video_sel != dram_sel))
		else $error("video area routed wrongly");

	AST_SEG_SHADOW: assert property (@(posedge clk) disable iff (srst)
		ce && cpu_valid && !cpu_write && fine && blk == SRM_BLK_BIOS
		&& sh_bios |=> dram_sel == $past(seg_sh))
		else $error("32k segment shadow not honoured");

	AST_GRAN_RESET: assert property (@(posedge clk)
		$fell(srst) |-> io_rdata == 16'h0000 && !fine_mode
		&& st.gran == SRM_GRAN_RST)
		else $error("granularity bit not zero after reset");

	AST_LOCK_HOLD: assert property (@(posedge clk) disable iff (srst)
		locked |=> $stable(st.cfg) && $stable(st.seg) && $stable(st.gran))
		else $error("register changed while locked");

	AST_WP_DROP: assert property (@(posedge clk) disable iff (srst)
		ce && cpu_valid && cpu_write && fine && blk == SRM_BLK_ADP
		&& sh_adp && seg_sh && seg_wp |=> wp_refused && !dram_sel)
		else $error("protected segment write reached dram");

	AST_ROLL_ELIG: assert property (@(posedge clk) disable iff (srst)
		roll_hit |-> elig[roll_area] && mem_1mb)
		else $error("roll mapped to an ineligible area");

	AST_ROLL_ALL4: assert property (@(posedge clk) disable iff (srst)
		ce && cpu_valid && roll_hit && elig == 4'hf
		&& cpu_addr[18:17] == 2'h0 && blk[6:3] != 4'h0
		&& blk != SRM_BLK_ALIAS
		|=> dram_sel && phys_addr[23:17] == SRM_BLK_EXTRA)
		else $error("four-area roll block a not extra");

endmodule

/* File: verif/srm_cpu_model.sv */
// processor bus model issuing memory cycles
`timescale 1ns/1ps
module srm_cpu_model (
	input  wire logic        clk,       // processor clock
	output logic             cpu_valid, // memory cycle present
	output logic             cpu_write, // cycle is a write
	output logic      [23:1] cpu_addr   // word address
);
	// idle bus flips the last pattern so a stale address never matches
	initial begin
		cpu_valid = 1'b0;
		cpu_write = 1'b0;
		cpu_addr  = 23'h000000;
	end
	// one cycle per request, released after the taking edge
	task automatic access(input logic [23:0] a, input logic w);
		@(posedge clk);
		cpu_valid <= 1'b1;
		cpu_write <= w;
		cpu_addr  <= a[23:1];
		@(posedge clk);
		cpu_valid <= 1'b0;
		cpu_write <= ~w;
		cpu_addr  <= ~a[23:1];
	endtask
endmodule

/* File: verif/srm_mapper_bench.sv */
// self-checking bench for the shadow and roll address mapper
`timescale 1ns/1ps
module srm_mapper_bench
	import srm_pkg::*;
;
	logic        clk = 1'b0;
	logic        srst = 1'b1;
	logic        ce = 1'b1;
	logic [7:0]  io_addr = 8'h00;
	logic        io_wr = 1'b0;
	logic        io_rd = 1'b0;
	logic [15:0] io_wdata = 16'h0000;
	logic [15:0] io_rdata;
	logic        cpu_valid;
	logic        cpu_write;
	logic [23:1] cpu_addr;
	logic [4:0]  roll_base = 5'h00;
	logic [2:0]  roll_blocks = 3'h0;
	logic        dram_sel;
	logic        rom_sel;
	logic        video_sel;
	logic [23:1] phys_addr;
	logic        wp_refused;
	logic        fine_mode;
	int          err_count = 0;
	int          checks_done = 0;
	int          cycles = 0;
	////////////////////////////////////////////////////////////////////
	srm_mapper u_srm_mapper (
		.clk(clk), .srst(srst), .ce(ce), .io_addr(io_addr),
		.io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
		.io_rdata(io_rdata), .cpu_valid(cpu_valid),
		.cpu_write(cpu_write), .cpu_addr(cpu_addr),
		.roll_base(roll_base), .roll_blocks(roll_blocks),
		.dram_sel(dram_sel), .rom_sel(rom_sel), .video_sel(video_sel),
		.phys_addr(phys_addr), .wp_refused(wp_refused),
		.fine_mode(fine_mode)
	);
	srm_cpu_model u_srm_cpu_model (
		.clk(clk), .cpu_valid(cpu_valid), .cpu_write(cpu_write),
		.cpu_addr(cpu_addr)
	);
	// 25 mhz clock and a hang guard well above the run length
	always #20 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			err_count++;
			final_report();
		end
	end
	////////////////////////////////////////////////////////////////////
	// verdict
	task automatic final_report();
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic check(input string n, input logic [31:0] s,
		input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	// register access, one strobe cycle each
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		io_addr  <= a;
		io_wdata <= d;
		io_wr    <= 1'b1;
		@(posedge clk);
		io_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		@(posedge clk);
		io_addr <= a;
		io_rd   <= 1'b1;
		@(posedge clk);
		io_rd <= 1'b0;
		@(posedge clk);
		#1;
		check("io_rdata", {16'h0000, io_rdata}, {16'h0000, e});
	endtask
	// es is {dram, rom, video, refused}; phys only checked for dram
	task automatic route(input logic [23:0] a, input logic w,
		input logic [3:0] es, input logic [23:0] ep);
		u_srm_cpu_model.access(a, w);
		#1;
		check("selects", {28'h0, dram_sel, rom_sel, video_sel,
			wp_refused}, {28'h0, es});
		if (es[3]) begin
			check("phys_addr", {8'h00, phys_addr, 1'b0}, {8'h00, ep});
		end
	endtask
	// map holds the physical block of roll blocks a to d, a lowest
	task automatic roll(input logic [4:0] rb, input logic [2:0] n,
		input logic [95:0] map);
		@(posedge clk);
		roll_base   <= rb;
		roll_blocks <= n;
		for (int k = 0; k < n; k++) begin
			route({rb, k[1:0], 17'h00006}, 1'b0, 4'h8,
				map[k*24 +: 24] + 24'h000006);
		end
	endtask
	////////////////////////////////////////////////////////////////////
	// main sequence: reset values, coarse, fine, roll, lock
	initial begin
		repeat (6) @(posedge clk);
		srst <= 1'b0;
		rd(SRM_CFG_OFS, 16'h0000);
		rd(SRM_GRAN_OFS, 16'h0000);
		rd(8'h24, 16'h0000);
		wr(SRM_CFG_OFS, 16'h0018);
		route(24'h0a0000, 1'b0, 4'h2, 24'h0);
		route(24'h0c0000, 1'b0, 4'h4, 24'h0);
		route(24'h0ffffe, 1'b1, 4'h4, 24'h0);
		route(24'h080000, 1'b0, 4'h8, 24'h080000);
		wr(SRM_CFG_OFS, 16'h0019);
		route(24'h0e0000, 1'b0, 4'h8, 24'h0e0000);
		route(24'h0dfffe, 1'b0, 4'h4, 24'h0);
		route(24'hfe0000, 1'b0, 4'h4, 24'h0);
		wr(SRM_CFG_OFS, 16'h0618);
		route(24'h0bfffe, 1'b1, 4'h8, 24'h0bfffe);
		route(24'h0e0000, 1'b0, 4'h4, 24'h0);
		wr(SRM_CFG_OFS, 16'h0010);
		route(24'h090000, 1'b0, 4'h0, 24'h0);
		// fine granularity, selects set before segments
		wr(SRM_GRAN_OFS, 16'hffff);
		rd(SRM_GRAN_OFS, 16'h0001);
		check("fine_mode", {31'h0, fine_mode}, 32'h1);
		wr(SRM_CFG_OFS, 16'h0619);
		wr(SRM_SEG_OFS, 16'h0011);
		route(24'h0c0000, 1'b0, 4'h8, 24'h0c0000);
		route(24'h0c8000, 1'b0, 4'h4, 24'h0);
		route(24'h0ffffe, 1'b0, 4'h4, 24'h0);
		route(24'h0a0000, 1'b0, 4'h8, 24'h0a0000);
		wr(SRM_SEG_OFS, 16'h0111);
		rd(SRM_SEG_OFS, 16'h0111);
		route(24'h0c0002, 1'b1, 4'h1, 24'h0);
		route(24'h0c0002, 1'b0, 4'h8, 24'h0c0002);
		route(24'h0e0000, 1'b1, 4'h8, 24'h0e0000);
		wr(SRM_GRAN_OFS, 16'h0000);
		route(24'h0c8000, 1'b1, 4'h8, 24'h0c8000);
		// clock enable low: a write must not land
		@(posedge clk);
		ce <= 1'b0;
		wr(SRM_GRAN_OFS, 16'h0001);
		@(posedge clk);
		ce <= 1'b1;
		rd(SRM_GRAN_OFS, 16'h0000);
		// roll region, compare set on a 512k boundary
		wr(SRM_SEG_OFS, 16'h0000);
		wr(SRM_CFG_OFS, 16'h0010);
		roll(5'h02, 3'h4, 96'h0e0000_0c0000_0a0000_080000);
		wr(SRM_CFG_OFS, 16'h0018);
		roll(5'h02, 3'h3, 96'h0_0c0000_0a0000_0e0000);
		wr(SRM_CFG_OFS, 16'h0019);
		roll(5'h02, 3'h2, 96'h0_0a0000_0c0000);
		wr(SRM_CFG_OFS, 16'h0618);
		roll(5'h04, 3'h1, 96'h0e0000);
		route(24'h1ffffe, 1'b0, 4'h8, 24'h1ffffe);
		route(24'h220000, 1'b0, 4'h8, 24'h220000);
		wr(SRM_CFG_OFS, 16'h0000);
		route(24'h200000, 1'b0, 4'h8, 24'h200000);
		// lock freezes every mapping register
		wr(SRM_CFG_OFS, 16'h8010);
		wr(SRM_CFG_OFS, 16'h0000);
		wr(SRM_GRAN_OFS, 16'h0001);
		rd(SRM_CFG_OFS, 16'h0000);
		check("fine_mode", {31'h0, fine_mode}, 32'h0);
		route(24'h200000, 1'b0, 4'h8, 24'h080000);
		final_report();
	end
endmodule
